// ---- design/sfh_host.sv ----
// APB-controlled driver for a self-timed 16x4 FIFO's pins
//
// The APB interface to the registers and the address map are this design's own decisions.
`include "sfh_regs.svh"
// How it works
// - Load rises only while input ready high.
// - Load strobe returns low between loads.
// - Never lower control while unload low.
// - Cascade ready to unload, valid to load.
// - Pulse clear on every stage before use.
// - Wide words AND the ready flags.
// - Load strobe low during whole clear pulse.
module sfh_host #(
  parameter int PULSE_CYC = `SFH_PULSE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // FIFO device pins
  input wire logic input_ready,
  input wire logic output_valid_flag,
  input wire logic [3:0] fifo_q,
  output logic [3:0] fifo_d,
  output logic load_strobe,
  output logic unload_strobe,
  output logic clear_input,
  output logic three_state_ctl
);
  typedef struct packed {
    sfh_pkg::sfh_state_e st;
    logic [`SFH_CNT_W-1:0] cnt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] d;
    logic ld;
    logic ul;
    logic clr;
    logic tsc;
    logic wpend;
    logic [3:0] rword;
    logic rval;
  } sfh_state_s;

  sfh_state_s r, next_r;
  logic acc, wr, rd;
  logic [`SFH_CNT_W-1:0] pulse_last;

  assign pulse_last = `SFH_CNT_W'(PULSE_CYC - 1);
  assign acc = psel && penable && !r.pready;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;

  // Next state: bus slave plus pin sequencer
  always_comb begin
    next_r = r;
    next_r.pready = acc;
    next_r.pslverr = 1'b0;
    next_r.prdata = 32'h0000_0000;
    if (rd) begin
      unique case (paddr)
        `SFH_CTRL_OFS: next_r.prdata = {29'h0000_0000, 1'b0, !r.tsc, r.clr};
        `SFH_RDATA_OFS: next_r.prdata = {28'h000_0000, r.rword};
        `SFH_STAT_OFS: next_r.prdata = {27'h000_0000, r.wpend, r.rval,
                                        output_valid_flag, input_ready,
                                        r.st != sfh_pkg::ST_IDLE};
        `SFH_WDATA_OFS: next_r.prdata = {28'h000_0000, r.d};
        default: next_r.pslverr = 1'b1;
      endcase
      if (paddr == `SFH_RDATA_OFS) begin
        next_r.rval = 1'b0;
      end
    end
    if (wr) begin
      unique case (paddr)
        `SFH_CTRL_OFS: begin
          // Outputs turn on only while unload idles high, else a word is lost
          // Limitation: an enable sent during an unload is dropped; read CTRL back
          if (!pwdata[`SFH_CTRL_OE]) begin
            next_r.tsc = 1'b1;
          end else if (r.ul) begin
            next_r.tsc = 1'b0;
          end
          if (pwdata[`SFH_CTRL_CLEAR] && r.st == sfh_pkg::ST_IDLE) begin
            next_r.st = sfh_pkg::ST_CLEAR;
            next_r.cnt = '0;
            next_r.clr = 1'b1;
          end
          if (pwdata[`SFH_CTRL_UNLOAD]) begin
            next_r.rval = 1'b0;
          end
        end
        `SFH_WDATA_OFS: begin
          next_r.d = pwdata[3:0];
          next_r.wpend = 1'b1;
        end
        `SFH_RDATA_OFS, `SFH_STAT_OFS: ;
        default: next_r.pslverr = 1'b1;
      endcase
    end
    // Pin sequencer; all strobes held at least one pulse width
    unique case (r.st)
      sfh_pkg::ST_IDLE: begin
        next_r.cnt = '0;
        // No start on a write cycle, so data and enable are settled first
        if (!wr) begin
          if (r.wpend && input_ready) begin
            next_r.st = sfh_pkg::ST_LOAD_HI;
            next_r.ld = 1'b1;
            next_r.wpend = 1'b0;
          end else if (!r.rval && output_valid_flag && !r.tsc) begin
            // Sample word then drop unload; skipped while outputs off
            next_r.rword = fifo_q;
            next_r.rval = 1'b1;
            next_r.st = sfh_pkg::ST_UNLOAD_LO;
            next_r.ul = 1'b0;
          end
        end
      end
      sfh_pkg::ST_CLEAR: begin
        next_r.ld = 1'b0;
        next_r.cnt = r.cnt + 1'b1;
        if (r.cnt == pulse_last) begin
          next_r.clr = 1'b0;
          // A word written in this last cycle stays pending
          if (!(wr && paddr == `SFH_WDATA_OFS)) begin
            next_r.wpend = 1'b0;
          end
          next_r.st = sfh_pkg::ST_IDLE;
        end
      end
      sfh_pkg::ST_LOAD_HI: begin
        next_r.cnt = r.cnt + 1'b1;
        if (r.cnt == pulse_last) begin
          next_r.ld = 1'b0;
          next_r.cnt = '0;
          next_r.st = sfh_pkg::ST_LOAD_LO;
        end
      end
      sfh_pkg::ST_LOAD_LO: begin
        next_r.cnt = r.cnt + 1'b1;
        if (r.cnt == pulse_last) begin
          next_r.st = sfh_pkg::ST_IDLE;
        end
      end
      sfh_pkg::ST_UNLOAD_LO: begin
        next_r.cnt = r.cnt + 1'b1;
        if (r.cnt == pulse_last) begin
          next_r.ul = 1'b1;
          next_r.cnt = '0;
          next_r.st = sfh_pkg::ST_UNLOAD_HI;
        end
      end
      sfh_pkg::ST_UNLOAD_HI: begin
        next_r.cnt = r.cnt + 1'b1;
        if (r.cnt == pulse_last) begin
          next_r.st = sfh_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // State register; unload idles high so its falling edge is the request
  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '{st: sfh_pkg::ST_IDLE, cnt: '0, prdata: 32'h0000_0000, pready: 1'b0,
             pslverr: 1'b0, d: 4'h0, ld: 1'b0, ul: 1'b1, clr: 1'b0, tsc: 1'b1,
             wpend: 1'b0, rword: 4'h0, rval: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign fifo_d = r.d;
  assign load_strobe = r.ld;
  assign unload_strobe = r.ul;
  assign clear_input = r.clr;
  assign three_state_ctl = r.tsc;

  // Checks on pin sequencing and APB ready timing
  load_ready_a: assert property (@(posedge clk) disable iff (srst)
    $rose(load_strobe) |-> $past(input_ready)) else $error("load without ready");
  load_width_a: assert property (@(posedge clk) disable iff (srst)
    $rose(load_strobe) |=> load_strobe [*7]) else $error("load pulse short");
  clear_load_a: assert property (@(posedge clk) disable iff (srst)
    clear_input |-> !load_strobe) else $error("load during clear");
  clear_width_a: assert property (@(posedge clk) disable iff (srst)
    $rose(clear_input) |-> clear_input [*8]) else $error("clear short");
  unload_tsc_a: assert property (@(posedge clk) disable iff (srst)
    $fell(unload_strobe) |-> !three_state_ctl) else $error("unload while off");
  unload_valid_a: assert property (@(posedge clk) disable iff (srst)
    $fell(unload_strobe) |-> $past(output_valid_flag)) else $error("unload empty");
  unload_width_a: assert property (@(posedge clk) disable iff (srst)
    $fell(unload_strobe) |-> !unload_strobe [*8] ##1 unload_strobe)
    else $error("unload pulse width");
  bus_ready_a: assert property (@(posedge clk) disable iff (srst)
    (psel && penable && !pready) |=> pready) else $error("apb late");
  tsc_unload_a: assert property (@(posedge clk) disable iff (srst)
    $fell(three_state_ctl) |-> $past(unload_strobe)) else $error("enable during unload");
  load_cv: cover property (@(posedge clk) disable iff (srst) $fell(load_strobe));
  unload_cv: cover property (@(posedge clk) disable iff (srst) $rose(unload_strobe));
  clear_cv: cover property (@(posedge clk) disable iff (srst) $fell(clear_input));
  enable_cv: cover property (@(posedge clk) disable iff (srst) $fell(three_state_ctl));
endmodule

// ---- design/sfh_regs.svh ----
// Register offsets, fields and pin timing counts for the FIFO pin controller
`ifndef SFH_REGS_SVH
`define SFH_REGS_SVH
`define SFH_CTRL_OFS 12'h000
`define SFH_WDATA_OFS 12'h004
`define SFH_RDATA_OFS 12'h008
`define SFH_STAT_OFS 12'h00C
`define SFH_CTRL_CLEAR 0
`define SFH_CTRL_OE 1
`define SFH_CTRL_UNLOAD 2
`define SFH_ST_BUSY 0
`define SFH_ST_IRDY 1
`define SFH_ST_OVAL 2
`define SFH_ST_RVAL 3
`define SFH_ST_WPEND 4
`define SFH_PULSE_NS 200
`define SFH_CLK_NS 25
`define SFH_PULSE_CYC ((`SFH_PULSE_NS + `SFH_CLK_NS - 1) / `SFH_CLK_NS)
`define SFH_CNT_W 4
`endif

// ---- design/sfh_pkg.sv ----
// Types for the FIFO pin controller
package sfh_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_CLEAR, ST_LOAD_HI, ST_LOAD_LO, ST_UNLOAD_LO, ST_UNLOAD_HI
  } sfh_state_e;
endpackage

// ---- dv/sfh_fifo_model.sv ----
// Behavioural model of the self-timed 16x4 FIFO device
module sfh_fifo_model (
  // Writer side
  input wire logic load_strobe,
  input wire logic [3:0] fifo_d,
  output logic input_ready = 1'b1,
  // Reader side
  input wire logic unload_strobe,
  input wire logic three_state_ctl,
  output logic output_valid_flag = 1'b0,
  output logic [3:0] fifo_q,
  // Clear
  input wire logic clear_input
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] words[$];
  logic [3:0] last_q = 4'h0;
  bit busy = 1'b0;
  // Rising strobe loads only with room; flag dips while word moves on
  always @(posedge load_strobe) if (input_ready && !clear_input) begin
    words.push_back(fifo_d);
    input_ready = 1'b0;
    #60 input_ready = words.size() < 16;
  end
  // Falling strobe unloads unless empty or outputs off
  always @(negedge unload_strobe) if (output_valid_flag && !three_state_ctl) begin
    output_valid_flag = 1'b0;
    busy = 1'b1;
    void'(words.pop_front());
    #50 busy = 1'b0;
    input_ready = 1'b1;
  end
  // Ripple is free-running; released outputs show inverted data, not old
  initial forever begin
    #5;
    if (words.size() > 0) last_q = words[0];
    if (!busy && words.size() > 0) output_valid_flag = 1'b1;
    fifo_q = three_state_ctl ? ~last_q : last_q;
  end
  // Clear drops all markers; data bits stay
  always @(posedge clear_input) begin
    words.delete();
    output_valid_flag = 1'b0;
    input_ready = 1'b1;
  end
endmodule

// ---- dv/testbench.sv ----
// Self-checking bench for the FIFO pin controller
`include "sfh_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PC = `SFH_PULSE_CYC;
  logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic pready, pslverr, ir, ov, ld, ul, clr, tsc;
  logic [3:0] d, q;
  logic [32:0] exp_q[$], e;
  logic [3:0] words[$];
  logic [31:0] seed = 32'hec58_d8ca;
  int n_errors = 0, samples_checked = 0;
  sfh_host #(.PULSE_CYC(PC)) dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .input_ready(ir), .output_valid_flag(ov), .fifo_q(q),
    .fifo_d(d), .load_strobe(ld), .unload_strobe(ul), .clear_input(clr),
    .three_state_ctl(tsc));
  sfh_fifo_model dev (.load_strobe(ld), .fifo_d(d), .input_ready(ir),
    .unload_strobe(ul), .three_state_ctl(tsc), .output_valid_flag(ov), .fifo_q(q),
    .clear_input(clr));
  // Clock
  initial forever #12.5 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  // Master holds the request until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so the next setup never reassigns psel in this step
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] x);
    exp_q.push_back(x);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  // Pin sequences have fixed lengths set by PC
  task automatic wt();
    repeat (4 * PC + 12) @(posedge clk);
  endtask
  task automatic put();
    r = rnd();
    words.push_back(r[3:0]);
    apb(1'b1, `SFH_WDATA_OFS, {28'h000_0000, r[3:0]});
    wt();
  endtask
  // Oldest note is compared when a read answers; bit 32 means error expected
  always @(posedge clk) if (psel && penable && pready === 1'b1 && !pwrite) begin
    e = exp_q.pop_front();
    if (e[32]) check({31'h0000_0000, pslverr}, 32'h0000_0001);
    else check(prdata, e[31:0]);
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (8000) @(posedge clk);
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(`SFH_STAT_OFS, 33'h0_0000_0002);
    rd(12'h010, 33'h1_0000_0000);
    $display("test reset done");
    apb(1'b1, `SFH_CTRL_OFS, 32'h0000_0001);
    rd(`SFH_CTRL_OFS, 33'h0_0000_0001);
    wt();
    repeat (17) put();
    rd(`SFH_STAT_OFS, 33'h0_0000_0014);
    $display("test fill done");
    apb(1'b1, `SFH_CTRL_OFS, 32'h0000_0002);
    rd(`SFH_CTRL_OFS, 33'h0_0000_0002);
    repeat (17) begin
      wt();
      rd(`SFH_RDATA_OFS, {29'h0000_0000, words.pop_front()});
    end
    wt();
    rd(`SFH_STAT_OFS, 33'h0_0000_0002);
    $display("test drain done");
    apb(1'b1, `SFH_CTRL_OFS, 32'h0000_0000);
    repeat (2) put();
    apb(1'b1, `SFH_CTRL_OFS, 32'h0000_0001);
    wt();
    apb(1'b1, `SFH_CTRL_OFS, 32'h0000_0002);
    wt();
    rd(`SFH_STAT_OFS, 33'h0_0000_0002);
    $display("test clear done");
    stop_test();
  end
endmodule
